//--- include/isc_pkg.sv
/*
 * Constants shared by the ISP, boot and security control logic: register
 * offsets, field positions, reset values and security word layout.
 * Assumes an 8-bit special-function register address space.
 */
`default_nettype none

package isc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_CHIP_CONTROL = 8'hBF;
    localparam logic [7:0] OFS_WRITE_UNLOCK = 8'hC6;
    localparam logic [7:0] OFS_SEC_SHADOW = 8'hC5;
    localparam logic [7:0] OFS_STATUS = 8'hC4;

    // control register fields
    localparam int unsigned BIT_SOFT_RESET = 7;
    localparam int unsigned BIT_AUX_RAM = 4;
    localparam int unsigned BIT_BOOT_SEL = 1;
    localparam int unsigned BIT_PROG_EN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // bits software may hold: 4, 1, 0 only
    localparam logic [7:0] CTRL_WR_MASK = 8'h13;

    // unlock sequence values
    localparam logic [7:0] UNLOCK_FIRST = 8'h87;
    localparam logic [7:0] UNLOCK_SECOND = 8'h59;

    // status register fields
    localparam int unsigned ST_ISP_MODE = 0;
    localparam int unsigned ST_IDLE_ARMED = 1;
    localparam int unsigned ST_FORCED_BOOT = 2;
    localparam int unsigned ST_UNLOCKED = 3;
    localparam int unsigned ST_CODE_LOCKED = 4;

    // security word location and layout
    localparam logic [15:0] SEC_WORD_ADDR = 16'hFFFF;
    localparam int unsigned SEC_LOCK = 0;
    localparam int unsigned SEC_TBL_INHIBIT = 1;
    localparam int unsigned SEC_ENCRYPT = 2;
    localparam int unsigned SEC_OSC_GAIN = 7;
    localparam logic [7:0] SEC_ERASED = 8'hFF;

    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ISC_NORMAL = 3'b001,
        ISC_IDLE_ARMED = 3'b010,
        ISC_PROGRAMMING = 3'b100
    } isc_mode_e;

endpackage

`default_nettype wire

//--- verilog/isc_sec_word.sv
/*
 * One-way security word: bits only move from 1 to 0 when programmed and
 * return to 1 only on an erase-all, a reset or a load from sec_image.
 * Assumes the nonvolatile image arrives on sec_image after reset release.
 */
`timescale 1ns/10ps
`default_nettype none

module isc_sec_word (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [7:0] sec_image,
    input wire logic prog,
    input wire logic [7:0] prog_data,
    input wire logic erase_all,
    output logic [7:0] word
);

    logic [7:0] word_q;
    logic [7:0] word_d;

    // programming can only clear bits; erase-all wins over a program
    assign word_d = erase_all ? isc_pkg::SEC_ERASED :
                    load ? sec_image :
                    prog ? (word_q & prog_data) : word_q; // R10

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            word_q <= isc_pkg::SEC_ERASED;
        end else begin
            word_q <= word_d;
        end
    end

    assign word = word_q;

endmodule

`default_nettype wire

//--- verilog/isc_control.sv
/*
 * ISP, boot-bank and code-security control for an 8-bit controller:
 * chip control register with unlock sequence, boot strap capture,
 * programming-mode entry, security word gating of flash and table reads.
 * Assumes a plain register port in the core clock domain and straps held
 * steady by the board across reset.
 */
// The plain strobed port was decided locally.
// Behaviour
// (R1) bits 7,1,0 written 1 cause full soft reset
// (R2) bit 7 reads 1 in forced loader boot
// (R3) control bit 4 enables auxiliary RAM
// (R4) bit 1 selects loader location and target bank; code uses it only for target_loader_bank, exec bank comes from the straps
// (R5) program enable enters ISP after idle wake-up
// (R6) program enable clear refuses all flash operations
// (R7) power-on boots application bank by default
// (R8) straps P2.7/P2.6 low or P4.3 low force loader
// (R9) security word blocked during programming mode
// (R10) security bits return to 1 only by erase-all; code also sets them to 1 on reset and loads sec_image on sec_load
// (R11) security word sits at 0FFFFH of loader space
// (R12) lock bit 0 denies flash and setting access
// (R13) inhibit 0: external table reads see external only
// (R14) inhibit 1: table reads unrestricted
// (R15) encryption encodes port 0 data, chip erase clears
// (R16) security bit 7 at 0 halves oscillator gain
// (R17) software unlocks control with 87H then 59H
// (R18) reserved bits read 0, bits 3,2 held 0
`timescale 1ns/10ps
`default_nettype none

module isc_control #(
    parameter logic [7:0] ENCRYPT_KEY = 8'hA5
) (
    input wire logic core_clk,
    input wire logic resetn,

    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,

    // boot straps
    input wire logic strap_p27,
    input wire logic strap_p26,
    input wire logic strap_p43,

    // cpu power state
    input wire logic cpu_idle,
    input wire logic wake_irq,
    output logic cpu_soft_reset,
    output logic exec_loader_bank,
    output logic aux_ram_enable,
    output logic target_loader_bank,
    output logic isp_mode,

    // flash operation requests
    input wire logic flash_op_req,
    output logic flash_op_grant,
    output logic flash_op_refused,

    // security word access
    input wire logic [7:0] sec_image,
    input wire logic sec_load,
    input wire logic sec_wr,
    input wire logic sec_rd,
    input wire logic [15:0] sec_addr,
    input wire logic sec_loader_space,
    input wire logic [7:0] sec_wdata,
    input wire logic erase_all,
    output logic [7:0] sec_rdata,
    output logic sec_access_denied,

    // code table reads
    input wire logic tbl_rd_req,
    input wire logic tbl_rd_from_ext,
    input wire logic tbl_rd_to_int,
    output logic tbl_rd_allow,

    // port 0 data path and oscillator
    input wire logic [7:0] p0_data_in,
    output logic [7:0] p0_data_out,
    output logic osc_half_gain
);

    function automatic logic [7:0] p0_encode(input logic [7:0] d,
                                             input logic en);
        logic [7:0] r;
        r = en ? (d ^ ENCRYPT_KEY) : d;
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        logic h;
        h = (a == o);
        return h;
    endfunction

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;

    logic forced_boot_q;
    logic strap_pending_q;
    logic soft_rst_q;

    logic got_first_q;
    logic got_first_d;
    logic unlocked_q;
    logic unlocked_d;

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] sec_rdata_q;
    logic [7:0] sec_rdata_d;

    logic [7:0] p0_q;

    isc_pkg::isc_mode_e mode_q;
    isc_pkg::isc_mode_e mode_d;

    logic [7:0] sec_word;

    logic ctrl_hit;
    logic unlock_hit;
    logic shadow_hit;
    logic status_hit;

    logic ctrl_write;
    logic soft_rst_req;

    logic forced_now;

    logic lock_ok;
    logic sec_addr_ok;
    logic sec_allowed;
    logic sec_prog;
    logic encrypt_on;

    logic [7:0] ctrl_view;
    logic [7:0] status_view;

    // address decode
    assign ctrl_hit = hit(reg_addr, isc_pkg::OFS_CHIP_CONTROL);
    assign unlock_hit = hit(reg_addr, isc_pkg::OFS_WRITE_UNLOCK);
    assign shadow_hit = hit(reg_addr, isc_pkg::OFS_SEC_SHADOW);
    assign status_hit = hit(reg_addr, isc_pkg::OFS_STATUS);

    // security word fields
    // erased bits read 1: open, unencrypted, full gain
    assign lock_ok = sec_word[isc_pkg::SEC_LOCK];
    assign encrypt_on = ~sec_word[isc_pkg::SEC_ENCRYPT];

    // control writes need the unlock sequence and an open lock bit
    assign ctrl_write = reg_wr & ctrl_hit & unlocked_q & lock_ok; // R12

    // soft reset needs reset, boot-select and program-enable all set
    assign soft_rst_req = ctrl_write
        & reg_wdata[isc_pkg::BIT_SOFT_RESET]
        & reg_wdata[isc_pkg::BIT_BOOT_SEL]
        & reg_wdata[isc_pkg::BIT_PROG_EN]; // R1

    // reserved and must-be-zero bits never stored
    // a soft reset wins over a same-cycle write
    assign ctrl_d = soft_rst_q ? isc_pkg::CTRL_RESET :
                    ctrl_write ? (reg_wdata & isc_pkg::CTRL_WR_MASK) :
                    ctrl_q; // R18

    // unlock: first value arms, second opens, anything else closes
    always_comb begin
        got_first_d = got_first_q;
        unlocked_d = unlocked_q;

        if (soft_rst_q) begin
            got_first_d = 1'b0;
            unlocked_d = 1'b0;
        end else if (reg_wr & unlock_hit) begin
            if (reg_wdata == isc_pkg::UNLOCK_FIRST) begin
                got_first_d = 1'b1;
                unlocked_d = 1'b0;
            end else if (reg_wdata == isc_pkg::UNLOCK_SECOND
                    && got_first_q) begin
                got_first_d = 1'b0;
                unlocked_d = 1'b1; // R17
            end else begin
                got_first_d = 1'b0;
                unlocked_d = 1'b0; // R17
            end
        end
    end

    // strap decode: both P2 straps low, or P4.3 low
    assign forced_now = (~strap_p27 & ~strap_p26) | ~strap_p43; // R8

    // programming-mode entry: armed by idle, entered on wake-up
    always_comb begin
        mode_d = mode_q;

        if (soft_rst_q) begin
            mode_d = isc_pkg::ISC_NORMAL;
        end else begin
            unique case (mode_q)
                isc_pkg::ISC_NORMAL: begin
                    if (ctrl_q[isc_pkg::BIT_PROG_EN] & cpu_idle) begin
                        mode_d = isc_pkg::ISC_IDLE_ARMED; // R5
                    end
                end

                isc_pkg::ISC_IDLE_ARMED: begin
                    if (!ctrl_q[isc_pkg::BIT_PROG_EN]) begin
                        mode_d = isc_pkg::ISC_NORMAL;
                    end else if (wake_irq) begin
                        mode_d = isc_pkg::ISC_PROGRAMMING; // R5
                    end
                end

                isc_pkg::ISC_PROGRAMMING: begin
                    if (!ctrl_q[isc_pkg::BIT_PROG_EN]) begin
                        mode_d = isc_pkg::ISC_NORMAL; // R6
                    end
                end

                default: begin
                    mode_d = isc_pkg::ISC_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= isc_pkg::CTRL_RESET;
            got_first_q <= 1'b0;
            unlocked_q <= 1'b0;
            mode_q <= isc_pkg::ISC_NORMAL;
        end else begin
            ctrl_q <= ctrl_d;
            got_first_q <= got_first_d;
            unlocked_q <= unlocked_d;
            mode_q <= mode_d;
        end
    end

    // soft reset pulse; straps re-sampled as on power-up
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            soft_rst_q <= 1'b0;
            strap_pending_q <= 1'b1;
            forced_boot_q <= 1'b0;
        end else begin
            soft_rst_q <= soft_rst_req; // R1
            strap_pending_q <= soft_rst_q;
            if (strap_pending_q) begin
                forced_boot_q <= forced_now; // R8
            end
        end
    end

    assign cpu_soft_reset = soft_rst_q; // R1

    // application bank unless straps forced the loader
    assign exec_loader_bank = forced_boot_q; // R7
    assign aux_ram_enable = ctrl_q[isc_pkg::BIT_AUX_RAM]; // R3

    assign target_loader_bank = ~ctrl_q[isc_pkg::BIT_BOOT_SEL]; // R4
    assign isp_mode = (mode_q == isc_pkg::ISC_PROGRAMMING);

    // flash operations run only in ISP, during idle, with lock open
    assign flash_op_grant = flash_op_req & ctrl_q[isc_pkg::BIT_PROG_EN]
        & isp_mode & cpu_idle & lock_ok; // R6
    assign flash_op_refused = flash_op_req & ~flash_op_grant; // R12

    // security word: one address in loader space, never in ISP
    assign sec_addr_ok = sec_loader_space
        & (sec_addr == isc_pkg::SEC_WORD_ADDR); // R11

    assign sec_allowed = sec_addr_ok & ~isp_mode & lock_ok; // R9
    assign sec_prog = sec_wr & sec_allowed; // R12
    assign sec_access_denied = (sec_wr | sec_rd) & ~sec_allowed; // R9

    isc_sec_word u_sec_word (
        .core_clk(core_clk),
        .resetn(resetn),
        .load(sec_load),
        .sec_image(sec_image),
        .prog(sec_prog),
        .prog_data(sec_wdata),
        .erase_all(erase_all),
        .word(sec_word)
    ); // R10

    // denied reads return zero, never stale data
    assign sec_rdata_d = (sec_rd & sec_allowed) ? sec_word
                                                : isc_pkg::READ_ZERO;

    // table reads into internal code gated by the inhibit bit
    assign tbl_rd_allow = tbl_rd_req & (~tbl_rd_to_int | ~tbl_rd_from_ext
        | sec_word[isc_pkg::SEC_TBL_INHIBIT]); // R13 R14

    // bit 7 of the view mirrors forced loader boot, not the stored bit
    assign ctrl_view = {forced_boot_q, 2'b00, ctrl_q[isc_pkg::BIT_AUX_RAM],
                        2'b00, ctrl_q[isc_pkg::BIT_BOOT_SEL],
                        ctrl_q[isc_pkg::BIT_PROG_EN]}; // R2 R18

    always_comb begin
        status_view = isc_pkg::READ_ZERO;

        status_view[isc_pkg::ST_ISP_MODE] = isp_mode;
        status_view[isc_pkg::ST_IDLE_ARMED] =
            (mode_q == isc_pkg::ISC_IDLE_ARMED);
        status_view[isc_pkg::ST_FORCED_BOOT] = forced_boot_q;
        status_view[isc_pkg::ST_UNLOCKED] = unlocked_q;
        status_view[isc_pkg::ST_CODE_LOCKED] = ~lock_ok;
    end

    // shadow reads obey the same gating as direct security access
    assign rdata_d = ~reg_rd ? isc_pkg::READ_ZERO :
                     ctrl_hit ? ctrl_view :
                     status_hit ? status_view :
                     (shadow_hit & ~isp_mode & lock_ok) ? sec_word :
                     isc_pkg::READ_ZERO; // R9 R12

    // port 0 data registered so encoding never glitches the bus
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= isc_pkg::READ_ZERO;
            sec_rdata_q <= isc_pkg::READ_ZERO;
            p0_q <= isc_pkg::READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
            sec_rdata_q <= sec_rdata_d;
            p0_q <= p0_encode(p0_data_in, encrypt_on); // R15
        end
    end

    assign reg_rdata = rdata_q;
    assign sec_rdata = sec_rdata_q;
    assign p0_data_out = p0_q;

    assign osc_half_gain = ~sec_word[isc_pkg::SEC_OSC_GAIN]; // R16

endmodule

`default_nettype wire

//--- sim/isc_control_monitor.sv
/* Port checker for isc_control.
   Assumes the bind below and a single core_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module isc_control_monitor #(
    parameter logic [7:0] ENCRYPT_KEY = 8'hA5
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_idle,
    input wire logic wake_irq,
    input wire logic cpu_soft_reset,
    input wire logic exec_loader_bank,
    input wire logic aux_ram_enable,
    input wire logic target_loader_bank,
    input wire logic isp_mode,
    input wire logic flash_op_req,
    input wire logic flash_op_grant,
    input wire logic flash_op_refused,
    input wire logic sec_load,
    input wire logic sec_wr,
    input wire logic sec_rd,
    input wire logic [15:0] sec_addr,
    input wire logic sec_loader_space,
    input wire logic erase_all,
    input wire logic [7:0] sec_rdata,
    input wire logic sec_access_denied,
    input wire logic tbl_rd_req,
    input wire logic tbl_rd_from_ext,
    input wire logic tbl_rd_to_int,
    input wire logic tbl_rd_allow,
    input wire logic [7:0] p0_data_in,
    input wire logic [7:0] p0_data_out,
    input wire logic osc_half_gain
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic ctrl_rd;
    logic swr_wr;
    logic sec_req;
    assign ctrl_rd = reg_rd && reg_addr == isc_pkg::OFS_CHIP_CONTROL;
    assign swr_wr = reg_wr && reg_addr == isc_pkg::OFS_CHIP_CONTROL
        && reg_wdata[7] && reg_wdata[1] && reg_wdata[0];
    assign sec_req = sec_rd || sec_wr;
    // pulse then settle: regs must be clear within one cycle after it
    sequence s_soft_pulse;
        cpu_soft_reset ##1 !cpu_soft_reset;
    endsequence
    property p_soft_cause;
        cpu_soft_reset |-> $past(swr_wr);
    endproperty
    property p_soft_clear;
        cpu_soft_reset |-> s_soft_pulse ##[0:1] (!aux_ram_enable && !isp_mode);
    endproperty
    property p_forced_read;
        $past(ctrl_rd) |-> reg_rdata[7] == $past(exec_loader_bank);
    endproperty
    property p_ctrl_bits;
        $past(ctrl_rd) |-> reg_rdata[4] == $past(aux_ram_enable)
            && reg_rdata[1] == !$past(target_loader_bank);
    endproperty
    property p_rsvd;
        $past(ctrl_rd) |-> reg_rdata[6:5] == 2'b00 && reg_rdata[3:2] == 2'b00;
    endproperty
    property p_isp_entry;
        $rose(isp_mode) |-> $past(wake_irq);
    endproperty
    property p_grant;
        flash_op_grant |-> flash_op_req && isp_mode && cpu_idle;
    endproperty
    property p_refuse;
        flash_op_refused == (flash_op_req && !flash_op_grant);
    endproperty
    property p_sec_isp;
        sec_req && isp_mode |-> sec_access_denied;
    endproperty
    property p_sec_addr;
        sec_req && (sec_addr != 16'hFFFF || !sec_loader_space)
            |-> sec_access_denied;
    endproperty
    property p_osc_oneway;
        $fell(osc_half_gain) |-> $past(erase_all || sec_load);
    endproperty
    property p_osc_read;
        $past(sec_rd && !sec_access_denied)
            |-> sec_rdata[7] == !$past(osc_half_gain);
    endproperty
    property p_tbl;
        tbl_rd_req && !(tbl_rd_from_ext && tbl_rd_to_int) |-> tbl_rd_allow;
    endproperty
    property p_p0;
        $past(resetn) |-> p0_data_out == $past(p0_data_in)
            || p0_data_out == ($past(p0_data_in) ^ ENCRYPT_KEY);
    endproperty
    a_soft_cause: assert property (p_soft_cause)
        else $error("soft reset pulse without qualifying write");
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset did not clear control state");
    a_forced_read: assert property (p_forced_read)
        else $error("control bit 7 differs from forced boot");
    a_ctrl_bits: assert property (p_ctrl_bits)
        else $error("control read differs from outputs");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bits not zero");
    a_isp_entry: assert property (p_isp_entry)
        else $error("programming mode entered without wake");
    a_grant: assert property (p_grant)
        else $error("flash operation granted outside programming");
    a_refuse: assert property (p_refuse)
        else $error("refusal flag wrong");
    a_sec_isp: assert property (p_sec_isp)
        else $error("security word reachable in programming mode");
    a_sec_addr: assert property (p_sec_addr)
        else $error("security word reachable at wrong address");
    a_osc_oneway: assert property (p_osc_oneway)
        else $error("security bit 7 returned to 1 without erase");
    a_osc_read: assert property (p_osc_read)
        else $error("gain select differs from security bit 7");
    a_tbl: assert property (p_tbl)
        else $error("table read wrongly blocked");
    a_p0: assert property (p_p0)
        else $error("port 0 data neither plain nor encoded");
endmodule
bind isc_control isc_control_monitor #(.ENCRYPT_KEY(ENCRYPT_KEY)) mon_i (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_idle, .wake_irq, .cpu_soft_reset, .exec_loader_bank, .aux_ram_enable,
    .target_loader_bank, .isp_mode, .flash_op_req, .flash_op_grant,
    .flash_op_refused, .sec_load, .sec_wr, .sec_rd, .sec_addr,
    .sec_loader_space, .erase_all, .sec_rdata, .sec_access_denied,
    .tbl_rd_req, .tbl_rd_from_ext, .tbl_rd_to_int, .tbl_rd_allow,
    .p0_data_in, .p0_data_out, .osc_half_gain);
`default_nettype wire

//--- sim/isc_boot_partner.sv
/* Board straps and programmer image loader facing isc_control.
   Assumes mode only changes while reset is held. */
`timescale 1ns/10ps
`default_nettype none
module isc_boot_partner #(
    parameter logic [7:0] IMAGE = 8'hFF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] mode,
    output logic strap_p27,
    output logic strap_p26,
    output logic strap_p43,
    output logic [7:0] sec_image,
    output logic sec_load
);
    logic loaded_q;
    // straps held steady across reset, 1: pair low, 2: p43 low
    assign strap_p27 = !(mode == 2'd1);
    assign strap_p26 = !(mode == 2'd1);
    assign strap_p43 = !(mode == 2'd2);
    assign sec_image = IMAGE;
    // image handed over once after each power-on release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
            sec_load <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
            sec_load <= !loaded_q;
        end
    end
endmodule
`default_nettype wire

//--- sim/isc_control_tb.sv
/* Self-checking bench for isc_control with a bench model.
   Assumes isc_pkg, the monitor and the boot partner are compiled. */
`timescale 1ns/10ps
`default_nettype none
module isc_control_tb;
    logic core_clk, resetn, reg_wr, reg_rd, cpu_idle, wake_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sec_image, sec_wdata;
    logic [7:0] sec_rdata, p0_data_in, p0_data_out;
    logic strap_p27, strap_p26, strap_p43, cpu_soft_reset, exec_loader_bank;
    logic aux_ram_enable, target_loader_bank, isp_mode, flash_op_req;
    logic flash_op_grant, flash_op_refused, sec_load, sec_wr, sec_rd;
    logic sec_loader_space, erase_all, sec_access_denied, tbl_rd_req;
    logic tbl_rd_from_ext, tbl_rd_to_int, tbl_rd_allow, osc_half_gain;
    logic [15:0] sec_addr;
    logic [1:0] boot_mode;
    logic [7:0] d;
    int num_errors, n_checks, n_soft, cyc, ctrl_m, word_m, unl_m, isp_m;
    int forced_m;
    isc_control #(.ENCRYPT_KEY(8'hA5)) isc_control_i (.core_clk, .resetn,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .strap_p27,
        .strap_p26, .strap_p43, .cpu_idle, .wake_irq, .cpu_soft_reset,
        .exec_loader_bank, .aux_ram_enable, .target_loader_bank, .isp_mode,
        .flash_op_req, .flash_op_grant, .flash_op_refused, .sec_image,
        .sec_load, .sec_wr, .sec_rd, .sec_addr, .sec_loader_space, .sec_wdata,
        .erase_all, .sec_rdata, .sec_access_denied, .tbl_rd_req,
        .tbl_rd_from_ext, .tbl_rd_to_int, .tbl_rd_allow, .p0_data_in,
        .p0_data_out, .osc_half_gain);
    isc_boot_partner isc_boot_partner_i (.core_clk, .resetn, .mode(boot_mode),
        .strap_p27, .strap_p26, .strap_p43, .sec_image, .sec_load);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cpu_soft_reset === 1'b1) n_soft++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] bf_m();
        return {forced_m[0], 2'b00, ctrl_m[4], 2'b00, ctrl_m[1:0]};
    endfunction
    task automatic do_reset(input logic [1:0] m);
        resetn <= 1'b0;
        boot_mode <= m;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        forced_m = (m != 2'd0);
        ctrl_m = 0;
        unl_m = 0;
        isp_m = 0;
        word_m = 255;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == isc_pkg::OFS_WRITE_UNLOCK)
            unl_m = (v == 8'h87) ? 1 : (v == 8'h59 && unl_m == 1) ? 2 : 0;
        else if (a == 8'hBF && unl_m == 2 && word_m[0]) begin
            ctrl_m = v & 8'h13;
            if (v[7] && v[1] && v[0]) begin
                ctrl_m = 0;
                unl_m = 0;
            end
        end
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
        @(posedge core_clk);
    endtask
    task automatic unlock;
        wr(isc_pkg::OFS_WRITE_UNLOCK, 8'h87);
        wr(isc_pkg::OFS_WRITE_UNLOCK, 8'h59);
    endtask
    task automatic sec(input logic w, input logic [7:0] v);
        logic ok;
        sec_wr <= w;
        sec_rd <= !w;
        sec_wdata <= v;
        #1 ok = !isp_m && word_m[0] && sec_addr == 16'hFFFF;
        chk("sec_denied", 8'(!ok), 8'(sec_access_denied));
        @(posedge core_clk);
        sec_wr <= 1'b0;
        sec_rd <= 1'b0;
        if (ok && w) word_m = word_m & v;
        #1 if (!w) chk("sec_rdata", ok ? word_m[7:0] : 8'h00, sec_rdata);
        @(posedge core_clk);
    endtask
    task automatic tbl_chk;
        for (int k = 0; k < 4; k++) begin
            tbl_rd_from_ext <= k[0];
            tbl_rd_to_int <= k[1];
            @(posedge core_clk);
            #1 chk("tbl_allow", 8'(k < 3 || word_m[1]), 8'(tbl_rd_allow));
        end
    endtask
    task automatic p0_chk;
        logic [7:0] v;
        v = 8'($urandom);
        p0_data_in <= v;
        @(posedge core_clk);
        #1 chk("p0_out", word_m[2] ? v : v ^ 8'hA5, p0_data_out);
    endtask
    initial begin
        {resetn, reg_wr, reg_rd, cpu_idle, wake_irq, flash_op_req} = '0;
        {sec_wr, sec_rd, erase_all, tbl_rd_req, tbl_rd_from_ext} = '0;
        {tbl_rd_to_int, reg_addr, reg_wdata, sec_wdata, p0_data_in} = '0;
        {num_errors, n_checks, n_soft, cyc} = '0;
        sec_addr = 16'hFFFF;
        sec_loader_space = 1'b1;
        boot_mode = 2'd0;
        void'($urandom(27402));
        do_reset(2'd0);
        chk("exec_loader", 8'h00, 8'(exec_loader_bank));
        rd(8'hBF, bf_m());
        rd(8'h10, 8'h00);
        wr(8'hBF, 8'h13);
        rd(8'hBF, bf_m());
        unlock();
        repeat (8) begin
            d = 8'($urandom) & 8'h7F;
            wr(8'hBF, d);
            rd(8'hBF, bf_m());
            chk("aux_ram", 8'(ctrl_m[4]), 8'(aux_ram_enable));
            chk("target", 8'(!ctrl_m[1]), 8'(target_loader_bank));
        end
        wr(8'hC6, 8'h00);
        wr(8'hBF, 8'h10);
        rd(8'hBF, bf_m());
        unlock();
        wr(8'hBF, 8'h82);
        chk("soft_count", 8'h00, 8'(n_soft));
        wr(8'hBF, 8'h83);
        rd(8'hBF, bf_m());
        chk("soft_count", 8'h01, 8'(n_soft));
        unlock();
        wr(8'hBF, 8'h01);
        cpu_idle <= 1'b1;
        repeat (2) @(posedge core_clk);
        wake_irq <= 1'b1;
        @(posedge core_clk);
        wake_irq <= 1'b0;
        flash_op_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        isp_m = 1;
        #1 chk("isp_mode", 8'h01, 8'(isp_mode));
        chk("grant", 8'h01, 8'(flash_op_grant));
        sec(1'b0, 8'h00);
        wr(8'hBF, 8'h00);
        repeat (2) @(posedge core_clk);
        isp_m = 0;
        #1 chk("refused", 8'h01, 8'(flash_op_refused));
        flash_op_req <= 1'b0;
        cpu_idle <= 1'b0;
        tbl_rd_req <= 1'b1;
        tbl_chk();
        p0_chk();
        sec(1'b1, 8'hFD);
        tbl_chk();
        sec(1'b1, 8'hFF);
        sec(1'b0, 8'h00);
        sec_addr <= 16'hFFFE;
        sec(1'b0, 8'h00);
        sec_addr <= 16'hFFFF;
        sec(1'b1, 8'hFB);
        rd(8'hC5, 8'(word_m));
        p0_chk();
        sec(1'b1, 8'h7F);
        chk("osc_half", 8'h01, 8'(osc_half_gain));
        erase_all <= 1'b1;
        @(posedge core_clk);
        erase_all <= 1'b0;
        word_m = 255;
        #1 chk("osc_half", 8'h00, 8'(osc_half_gain));
        sec(1'b0, 8'h00);
        p0_chk();
        sec(1'b1, 8'hFE);
        sec(1'b0, 8'h00);
        rd(8'hC5, 8'h00);
        unlock();
        wr(8'hBF, 8'h10);
        rd(8'hBF, bf_m());
        for (int m = 1; m < 3; m++) begin
            do_reset(2'(m));
            chk("exec_loader", 8'h01, 8'(exec_loader_bank));
            rd(8'hBF, bf_m());
            rd(8'hC4, 8'h04);
        end
        stop_test();
    end
endmodule
`default_nettype wire
